// ==== verilog/cis_sequencer.sv ====
// interrupt and reset vectoring logic beside a small cpu sequencer
// assumes the sequencer pulses instruction-boundary and opcode strobes on clk
`default_nettype none
module cis_sequencer
   import cis_pkg::*;
#(
   parameter logic [15:0] BOOT_START = cis_pkg::BOOT_START_RESET
)(
   input  wire  logic                          clk,
   input  wire  logic                          rst,
   input  wire  logic [cis_pkg::ADDR_W-1:0]    regAddr,
   input  wire  logic [cis_pkg::DATA_W-1:0]    regWrData,
   input  wire  logic                          regWr,
   input  wire  logic                          regRd,
   output logic       [cis_pkg::DATA_W-1:0]    regRdData,
   input  wire  logic [cis_pkg::NUM_SRC-1:0]   srcEvent,
   input  wire  logic                          instrBoundary,
   input  wire  logic                          disableInstr,
   input  wire  logic                          enableInstr,
   input  wire  logic                          returnInstr,
   input  wire  logic                          sleeping,
   input  wire  logic [cis_pkg::PC_W-1:0]      pc,
   input  wire  logic                          bootResetFuse,
   input  wire  logic                          appLockBit,
   input  wire  logic                          bootLockBit,
   output logic                                irqTake,
   output logic       [cis_pkg::PC_W-1:0]      vectorAddr,
   output logic                                seqBusy,
   output logic                                pushPc,
   output logic                                popPc,
   output logic                                spInc2
);
   import cis_pkg::*;

   // ***********************************
   // registers
   // ***********************************
   logic                  gie;
   logic                  reloc;
   logic [NUM_SRC-1:0]    enable;
   logic [NUM_SRC-1:0]    flags;
   logic [NUM_SRC-1:0]    kind;
   cis_state_t            state;
   logic [3:0]            count;
   logic                  holdOff;
   logic                  resetVecDone;
   logic                  pendingSel;
   logic [2:0]            selIdx;
   logic [NUM_SRC-1:0]    request;
   logic                  inBoot;
   logic                  lockBlock;
   logic                  mayTake;

   function automatic logic [2:0] lowestSet(input logic [NUM_SRC-1:0] v);
      lowestSet = 3'd0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowestSet = 3'(i);
         end
      end
   endfunction

   function automatic logic [15:0] vecBase(input logic moved);
      vecBase = moved ? BOOT_START : 16'h0000;
   endfunction

   // ***********************************
   // request selection
   // ***********************************
   always_comb begin
      // flag sources use latched flag, level sources the live condition
      request   = ((flags & kind) | (srcEvent & ~kind)) & enable;
      inBoot    = (pc >= BOOT_START);
      // an app lock bars interrupts while running in app code, boot lock likewise
      lockBlock = (appLockBit & ~inBoot) | (bootLockBit & inBoot);
      pendingSel = |request;
      selIdx    = lowestSet(request);
      // disable instruction wins over a same-cycle request
      mayTake   = gie & ~disableInstr & ~holdOff & ~lockBlock
                & instrBoundary & (state == S_RUN) & resetVecDone;
   end

   // ***********************************
   // sequencer
   // ***********************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= S_RUN;
         count <= 4'h0;
      end else begin
         case (state)
            S_RUN: begin
               if (mayTake && pendingSel) begin
                  state <= sleeping ? S_WAKE : S_ENTRY;
                  count <= 4'h0;
               end else if (returnInstr && instrBoundary) begin
                  state <= S_RETURN;
                  count <= 4'h0;
               end
            end
            S_WAKE: begin
               count <= count + 4'h1;
               if (count == 4'(WAKE_EXTRA - 1)) begin
                  state <= S_ENTRY;
                  count <= 4'h0;
               end
            end
            S_ENTRY, S_RETURN: begin
               count <= count + 4'h1;
               if (count == 4'(ENTRY_CYCLES - 1)) begin
                  state <= S_RUN;
                  count <= 4'h0;
               end
            end
            default: begin
               state <= S_RUN;
               count <= 4'h0;
            end
         endcase
      end
   end

   // one boundary must pass after return or enable before taking
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         holdOff <= 1'b0;
      end else if ((state == S_RETURN && count == 4'(RETURN_CYCLES - 1)) || enableInstr) begin
         holdOff <= 1'b1;
      end else if (instrBoundary && state == S_RUN) begin
         holdOff <= 1'b0;
      end
   end

   // ***********************************
   // global enable
   // ***********************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gie <= 1'b0;
      end else if (mayTake && pendingSel) begin
         gie <= 1'b0;
      end else if (state == S_RETURN && count == 4'(RETURN_CYCLES - 1)) begin
         gie <= 1'b1;
      end else if (disableInstr) begin
         gie <= 1'b0;
      end else if (enableInstr) begin
         gie <= 1'b1;
      end else if (regWr && regAddr == ADDR_STATUS) begin
         gie <= regWrData[GIE_BIT];
      end
   end

   // ***********************************
   // flags, software registers
   // ***********************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags <= '0;
      end else begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (srcEvent[i] && kind[i]) begin
               flags[i] <= 1'b1;
            end else if (mayTake && pendingSel && selIdx == 3'(i)) begin
               flags[i] <= 1'b0;
            end else if (regWr && regAddr == ADDR_FLAGS && regWrData[i]) begin
               flags[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reloc  <= 1'b0;
         enable <= '0;
         kind   <= KIND_RESET;
      end else if (regWr) begin
         case (regAddr)
            ADDR_CTRL:   reloc  <= regWrData[RELOC_BIT];
            ADDR_ENABLE: enable <= regWrData;
            ADDR_KIND:   kind   <= regWrData;
            default:     reloc  <= reloc;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdData <= '0;
      end else if (regRd) begin
         case (regAddr)
            ADDR_STATUS: regRdData <= {gie, 7'h00};
            ADDR_CTRL:   regRdData <= {6'h00, reloc, 1'b0};
            ADDR_ENABLE: regRdData <= enable;
            ADDR_FLAGS:  regRdData <= flags;
            ADDR_KIND:   regRdData <= kind;
            ADDR_STATE:  regRdData <= {4'h0, count};
            default:     regRdData <= '0;
         endcase
      end else begin
         regRdData <= '0;
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         resetVecDone <= 1'b0;
         vectorAddr   <= '0;
         irqTake      <= 1'b0;
      end else if (!resetVecDone) begin
         // reset vector issued first, it outranks everything
         resetVecDone <= 1'b1;
         vectorAddr   <= bootResetFuse ? BOOT_START : 16'h0000;
         irqTake      <= 1'b0;
      end else if (mayTake && pendingSel) begin
         // vector 0 is reset, source n sits at slot n+1
         vectorAddr <= vecBase(reloc) + VEC_STRIDE * 16'({13'h0, selIdx} + 16'h1);
         irqTake    <= 1'b1;
      end else begin
         irqTake <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seqBusy <= 1'b0;
         pushPc  <= 1'b0;
         popPc   <= 1'b0;
         spInc2  <= 1'b0;
      end else begin
         seqBusy <= (state != S_RUN);
         pushPc  <= (state == S_ENTRY);
         popPc   <= (state == S_RETURN);
         spInc2  <= (state == S_RETURN && count == 4'h0);
      end
   end

   // ***********************************
   // checks
   // ***********************************
   a_take_needs_gie: assert property (@(posedge clk) disable iff (rst)
      irqTake |-> $past(gie) && !$past(disableInstr)) else $error("take without enable");
   a_entry_clears_gie: assert property (@(posedge clk) disable iff (rst)
      (mayTake && pendingSel) |=> !gie) else $error("enable kept on entry");
   a_entry_len: assert property (@(posedge clk) disable iff (rst)
      $rose(state == S_ENTRY) |-> (state == S_ENTRY) [*5] ##1 state == S_RUN)
      else $error("entry length wrong");
   a_wake_len: assert property (@(posedge clk) disable iff (rst)
      $rose(state == S_WAKE) |-> (state == S_WAKE) [*5] ##1 state == S_ENTRY)
      else $error("wake length wrong");
   a_return_sets: assert property (@(posedge clk) disable iff (rst)
      $rose(state == S_RETURN) |-> ##5 gie) else $error("return left enable off");
   a_flag_clear_one: assert property (@(posedge clk) disable iff (rst)
      (regWr && regAddr == ADDR_FLAGS && regWrData[0] && !srcEvent[0]) |=> !flags[0])
      else $error("flag not cleared");
   a_flag_hold: assert property (@(posedge clk) disable iff (rst)
      (srcEvent[0] && kind[0]) |=> flags[0]) else $error("flag lost");
   a_level_only: assert property (@(posedge clk) disable iff (rst)
      (!kind[0] && !srcEvent[0]) |-> !request[0]) else $error("level ghost");
   a_lock_block: assert property (@(posedge clk) disable iff (rst)
      lockBlock |-> !mayTake) else $error("lock ignored");
   a_boundary_hold: assert property (@(posedge clk) disable iff (rst)
      enableInstr |=> !mayTake) else $error("took before next instr");
   c_entry: cover property (@(posedge clk) mayTake && pendingSel);
   c_wake: cover property (@(posedge clk) state == S_WAKE);
   c_return: cover property (@(posedge clk) state == S_RETURN);
   c_relocated: cover property (@(posedge clk) irqTake && reloc);
   c_level_take: cover property (@(posedge clk) mayTake && pendingSel && !kind[selIdx]);

   // ***********************************
   // checks on the cpu-facing strobes and internal state
   // ***********************************
   // the strobe checks watch registered outputs, so a broken decode shows even if the
   // internal terms above still agree; later ones here check gie, flags, count and holdOff
   a_take_pulse: assert property (@(posedge clk) disable iff (rst)
      irqTake |=> !irqTake)
      else $error("take longer than one cycle");
   a_take_enters: assert property (@(posedge clk) disable iff (rst)
      irqTake |-> (state == S_ENTRY || state == S_WAKE))
      else $error("take without entry");
   a_push_len: assert property (@(posedge clk) disable iff (rst)
      $rose(pushPc) |-> pushPc [*5] ##1 !pushPc)
      else $error("push strobe length wrong");
   a_pop_len: assert property (@(posedge clk) disable iff (rst)
      $rose(popPc) |-> popPc [*5] ##1 !popPc)
      else $error("pop strobe length wrong");
   a_sp_with_pop: assert property (@(posedge clk) disable iff (rst)
      spInc2 |-> $rose(popPc))
      else $error("stack step outside return start");
   a_busy_entry: assert property (@(posedge clk) disable iff (rst)
      $rose(pushPc) |-> seqBusy)
      else $error("push while idle");
   a_no_take_busy: assert property (@(posedge clk) disable iff (rst)
      seqBusy |-> !irqTake)
      else $error("take while busy");
   a_take_boundary: assert property (@(posedge clk) disable iff (rst)
      irqTake |-> $past(instrBoundary))
      else $error("take off a boundary");
   a_take_unlocked: assert property (@(posedge clk) disable iff (rst)
      irqTake |-> !$past(lockBlock))
      else $error("take inside locked region");
   a_vec_low: assert property (@(posedge clk) disable iff (rst)
      (irqTake && !$past(reloc)) |-> (vectorAddr <= 16'(2 * NUM_SRC) && !vectorAddr[0]))
      else $error("vector outside low table");
   a_vec_reloc: assert property (@(posedge clk) disable iff (rst)
      (irqTake && $past(reloc)) |-> vectorAddr >= BOOT_START)
      else $error("vector not relocated");
   a_disable_now: assert property (@(posedge clk) disable iff (rst)
      (disableInstr && state == S_RUN) |=> !gie)
      else $error("disable not immediate");
   a_enable_sets: assert property (@(posedge clk) disable iff (rst)
      (enableInstr && !disableInstr && !(mayTake && pendingSel)) |=> gie)
      else $error("enable instruction ignored");
   a_status_write: assert property (@(posedge clk) disable iff (rst)
      (regWr && regAddr == ADDR_STATUS && regWrData[GIE_BIT] && !disableInstr
         && !(mayTake && pendingSel)) |=> gie)
      else $error("handler could not reopen enable");
   a_flags_latch: assert property (@(posedge clk) disable iff (rst)
      ((srcEvent & kind) != '0) |=> ((flags & $past(srcEvent & kind)) == $past(srcEvent & kind)))
      else $error("event not latched");
   a_hw_clear: assert property (@(posedge clk) disable iff (rst)
      (mayTake && pendingSel && !srcEvent[selIdx]) |=> !flags[$past(selIdx)])
      else $error("served flag left set");
   a_wake_no_push: assert property (@(posedge clk) disable iff (rst)
      (state == S_WAKE) |=> !pushPc)
      else $error("push during wake delay");
   a_count_bound: assert property (@(posedge clk) disable iff (rst)
      count <= 4'(ENTRY_CYCLES - 1))
      else $error("sequence counter overran");
   a_hold_after_ret: assert property (@(posedge clk) disable iff (rst)
      (state == S_RETURN && count == 4'(RETURN_CYCLES - 1)) |=> holdOff)
      else $error("no hold after return");
   a_hold_release: assert property (@(posedge clk) disable iff (rst)
      (holdOff && instrBoundary && state == S_RUN && !enableInstr
         && !(state == S_RETURN)) |=> !holdOff)
      else $error("hold never released");
   a_reset_vec: assert property (@(posedge clk) disable iff (rst)
      $rose(resetVecDone) |-> vectorAddr == ($past(bootResetFuse) ? BOOT_START : 16'h0000))
      else $error("reset vector wrong");
   a_reset_first: assert property (@(posedge clk) disable iff (rst)
      !resetVecDone |=> !irqTake)
      else $error("interrupt before reset vector");
   // read data must fall back to zero so a stale byte is never mistaken for an answer
   a_read_idle: assert property (@(posedge clk) disable iff (rst)
      !regRd |=> regRdData == '0)
      else $error("read data without a read");
endmodule // cis_sequencer
`default_nettype wire

// ==== verilog/cis_pkg.sv ====
// constants for the interrupt and reset vectoring sequencer
// assumes a single cpu clock domain and word-addressed program memory
`default_nettype none
package cis_pkg;
   // ***********************************
   // sizes
   // ***********************************
   localparam int NUM_SRC   = 8;
   localparam int PC_W      = 16;
   localparam int ADDR_W    = 4;
   localparam int DATA_W    = 8;
   // ***********************************
   // register map, word indices
   // ***********************************
   localparam logic [3:0] ADDR_STATUS  = 4'h0;  // global enable in bit 7
   localparam logic [3:0] ADDR_CTRL    = 4'h1;  // relocate bit 1
   localparam logic [3:0] ADDR_ENABLE  = 4'h2;
   localparam logic [3:0] ADDR_FLAGS   = 4'h3;  // write one to clear
   localparam logic [3:0] ADDR_KIND    = 4'h4;  // 1 = flag source, 0 = level
   localparam logic [3:0] ADDR_STATE   = 4'h5;  // sequencer step counter readback
   localparam int GIE_BIT   = 7;
   localparam int RELOC_BIT = 1;
   localparam logic [7:0] KIND_RESET = 8'hFF;
   // ***********************************
   // vectors and timing
   // ***********************************
   localparam logic [15:0] BOOT_START_RESET = 16'hF000;
   localparam logic [15:0] VEC_STRIDE       = 16'h0002;
   localparam int ENTRY_CYCLES  = 5;
   localparam int WAKE_EXTRA    = 5;
   localparam int RETURN_CYCLES = 5;
   typedef enum logic [2:0] {S_RUN, S_WAKE, S_ENTRY, S_RETURN} cis_state_t;
endpackage
`default_nettype wire

// ==== bench/cis_cpu_model.sv ====
// cpu sequencer model: instruction boundaries, opcode strobes, pc
// assumes the interrupt sequencer shares clk and rst
`default_nettype none
module cis_cpu_model
   import cis_pkg::*;
#(
   parameter int GAP = 2
)(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        seqBusy,
   input  wire logic        irqTake,
   input  wire logic [15:0] vectorAddr,
   input  wire logic [1:0]  opReq,
   output logic             opDone,
   output logic             instrBoundary,
   output logic             disableInstr,
   output logic             enableInstr,
   output logic             returnInstr,
   output logic      [15:0] pc
);
   timeunit 1ns;
   timeprecision 1ps;
   // handler code owns saving the status byte; no save is modelled here
   int         cnt;
   logic [1:0] op;
   // ****************
   // instruction stream
   // ****************
   // multi-cycle instructions end on the last cycle only; no boundary while busy
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         instrBoundary <= 1'b0;
         op <= 2'h0;
      end else if (seqBusy || irqTake) begin
         cnt <= 0;
         instrBoundary <= 1'b0;
         op <= 2'h0;
      end else begin
         cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
         instrBoundary <= (cnt == GAP - 1);
         op <= (cnt == GAP - 1) ? opReq : 2'h0;
      end
   end
   assign opDone = (op != 2'h0);
   assign disableInstr = (op == 2'h1);
   assign enableInstr = (op == 2'h2);
   assign returnInstr = (op == 2'h3);
   // handler code is not modelled, so a return leaves pc in the handler
   always_ff @(posedge clk or posedge rst) begin
      if (rst) pc <= 16'h0100;
      else if (irqTake) pc <= vectorAddr;
      else if (instrBoundary) pc <= pc + 16'h0001;
   end
endmodule  // cis_cpu_model
`default_nettype wire

// ==== bench/cis_sequencer_test.sv ====
// self-checking bench for the interrupt sequencer
// assumes cis_pkg and the cpu model are compiled first
`default_nettype none
module cis_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cis_pkg::*;
   localparam logic [15:0] BOOT = BOOT_START_RESET;
   logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, sleeping = 1'b0;
   logic bootResetFuse = 1'b0, appLockBit = 1'b0, bootLockBit = 1'b0;
   logic [3:0]  regAddr = 4'h0;
   logic [7:0]  regWrData = 8'h00, srcEvent = 8'h00, regRdData;
   logic [1:0]  opReq = 2'h0;
   logic [15:0] vectorAddr, pc;
   logic irqTake, seqBusy, pushPc, popPc, spInc2, opDone;
   logic instrBoundary, disableInstr, enableInstr, returnInstr;
   int fail_count = 0;
   int compares = 0;
   int seed = 25;
   int idx, a, b;
   always #25 clk = ~clk;
   cis_sequencer #(.BOOT_START(BOOT)) i_cis_sequencer (.clk(clk), .rst(rst),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .srcEvent(srcEvent), .instrBoundary(instrBoundary),
      .disableInstr(disableInstr), .enableInstr(enableInstr), .returnInstr(returnInstr),
      .sleeping(sleeping), .pc(pc), .bootResetFuse(bootResetFuse), .appLockBit(appLockBit),
      .bootLockBit(bootLockBit), .irqTake(irqTake), .vectorAddr(vectorAddr), .seqBusy(seqBusy),
      .pushPc(pushPc), .popPc(popPc), .spInc2(spInc2));
   cis_cpu_model i_cis_cpu_model (.clk(clk), .rst(rst), .seqBusy(seqBusy), .irqTake(irqTake),
      .vectorAddr(vectorAddr), .opReq(opReq), .opDone(opDone), .instrBoundary(instrBoundary),
      .disableInstr(disableInstr), .enableInstr(enableInstr), .returnInstr(returnInstr),
      .pc(pc));
   // ****************
   // reference model and bus tasks
   // ****************
   function automatic logic [15:0] expVec(input int i, input bit reloc);
      return (reloc ? BOOT : 16'h0000) + VEC_STRIDE * 16'(i + 1);
   endfunction
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk) begin regWr <= 1'b1; regAddr <= ad; regWrData <= d; end
      @(posedge clk) regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] ad, input logic [7:0] e);
      @(posedge clk) begin regRd <= 1'b1; regAddr <= ad; end
      @(posedge clk) regRd <= 1'b0;
      @(negedge clk) check("regRdData", {8'h00, e}, {8'h00, regRdData});
   endtask
   // entry is counted over a fixed window so a stuck busy shows as a wrong count
   task automatic take(input logic [15:0] e, input int busyExp);
      int push, busy;
      push = 0;
      busy = 0;
      repeat (60) begin @(negedge clk); if (irqTake === 1'b1) break; end
      check("irqTake", 16'h0001, {15'h0000, irqTake});
      check("vectorAddr", e, vectorAddr);
      repeat (30) begin push += int'(pushPc === 1'b1); busy += int'(seqBusy === 1'b1);
         @(negedge clk); end
      check("pushPc cycles", 16'(ENTRY_CYCLES), 16'(push));
      check("seqBusy cycles", 16'(busyExp), 16'(busy));
   endtask
   task automatic noTake(input int n);
      logic hit;
      hit = 1'b0;
      repeat (n) begin @(negedge clk); if (irqTake !== 1'b0) hit = 1'b1; end
      check("no irqTake", 16'h0000, {15'h0000, hit});
   endtask
   task automatic op(input logic [1:0] c);
      @(posedge clk) opReq <= c;
      repeat (20) begin @(negedge clk); if (opDone === 1'b1) break; end
      @(posedge clk) opReq <= 2'h0;
   endtask
   task automatic pulse(input logic [7:0] s);
      @(posedge clk) srcEvent <= s;
      @(posedge clk) srcEvent <= 8'h00;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ****************
   // scenarios
   // ****************
   initial begin
      #(3000 * 50);
      fail_count++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      check("reset vector", 16'h0000, vectorAddr);
      rd(ADDR_KIND, KIND_RESET);
      rd(4'hF, 8'h00);
      rd(ADDR_STATUS, 8'h00);
      idx = int'($unsigned($random(seed)) % 8);
      wr(ADDR_ENABLE, 8'(1 << idx));
      pulse(8'(1 << idx));
      noTake(10);
      rd(ADDR_FLAGS, 8'(1 << idx));
      wr(ADDR_STATUS, 8'h80);
      take(expVec(idx, 1'b0), ENTRY_CYCLES);
      rd(ADDR_STATUS, 8'h00);
      rd(ADDR_FLAGS, 8'h00);
      op(2'h3);
      a = 0;
      b = 0;
      repeat (12) begin @(negedge clk); a += int'(popPc === 1'b1); b += int'(spInc2 === 1'b1); end
      check("popPc cycles", 16'(RETURN_CYCLES), 16'(a));
      check("spInc2 pulses", 16'h0001, 16'(b));
      rd(ADDR_STATUS, 8'h80);
      wr(ADDR_STATUS, 8'h00);
      wr(ADDR_CTRL, 8'h02);
      wr(ADDR_ENABLE, 8'hFF);
      pulse(8'h24);
      wr(ADDR_STATUS, 8'h80);
      take(expVec(2, 1'b1), ENTRY_CYCLES);
      wr(ADDR_STATUS, 8'h80);
      take(expVec(5, 1'b1), ENTRY_CYCLES);
      wr(ADDR_CTRL, 8'h00);
      pulse(8'h0C);
      wr(ADDR_FLAGS, 8'h04);
      rd(ADDR_FLAGS, 8'h08);
      wr(ADDR_FLAGS, 8'h08);
      rd(ADDR_FLAGS, 8'h00);
      wr(ADDR_KIND, 8'hFE);
      pulse(8'h01);
      wr(ADDR_STATUS, 8'h80);
      noTake(12);
      @(posedge clk) srcEvent <= 8'h01;
      take(expVec(0, 1'b0), ENTRY_CYCLES);
      @(posedge clk) appLockBit <= 1'b1;
      wr(ADDR_STATUS, 8'h80);
      noTake(12);
      @(posedge clk) begin appLockBit <= 1'b0; bootLockBit <= 1'b1; sleeping <= 1'b1; end
      take(expVec(0, 1'b0), ENTRY_CYCLES + WAKE_EXTRA);
      @(posedge clk) begin sleeping <= 1'b0; bootLockBit <= 1'b0; end
      op(2'h2);
      noTake(3);
      take(expVec(0, 1'b0), ENTRY_CYCLES);
      op(2'h2);
      op(2'h1);
      noTake(12);
      rd(ADDR_STATUS, 8'h00);
      @(posedge clk) begin srcEvent <= 8'h00; bootResetFuse <= 1'b1; end
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      check("fuse reset vector", BOOT, vectorAddr);
      end_of_test();
   end
endmodule  // cis_sequencer_test
`default_nettype wire
